// ### design/hsc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pins are asynchronous to mclk_i; output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module hsc_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_i,    // System clock
    input  wire logic             rst_n_i,   // Synchronous reset, active low
    input  wire logic             clk_en_i,  // Clock enable
    input  wire logic [WIDTH-1:0] pin_i,     // Asynchronous pin levels
    output logic      [WIDTH-1:0] level_o    // Filtered levels
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } hsc_sync_t;

    hsc_sync_t r;
    hsc_sync_t next_r;

    always_comb
    begin
        next_r    = r;
        next_r.s1 = pin_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (r.s2[i] == r.s3[i])
            begin
                next_r.level[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            r <= '0;
        end
        else if (clk_en_i)
        begin
            r <= next_r;
        end
    end

    assign level_o = r.level;

endmodule : hsc_pin_sync

`default_nettype wire

// ### design/hsc_pkg.sv
// Constants for the hub strap and status pin configuration block.
// Assumes a single 20 MHz clock and plain-port control from the hub core.
package hsc_pkg;

    localparam int          PORT_COUNT      = 4;    // Downstream power enables
    localparam int          SYNC_STAGES     = 3;    // Pin synchroniser depth
    localparam logic [2:0]  SETTLE_CYCLES   = 3'h4; // Synchroniser and filter latency
    localparam logic [2:0]  SETTLE_INIT     = 3'h0;

    // Bus mode select pin levels
    localparam logic        MODE_SMBUS      = 1'h0;
    localparam logic        MODE_I2C        = 1'h1;

    // Polarity strap levels
    localparam logic        POL_ACTIVE_LOW  = 1'h0;
    localparam logic        POL_ACTIVE_HIGH = 1'h1;

    // Ganged strap levels
    localparam logic        PWR_INDIVIDUAL  = 1'h0;
    localparam logic        PWR_GANGED      = 1'h1;

    // Field positions of the billboard configuration-state field
    localparam int          CFG_BIT0        = 0;
    localparam int          CFG_BIT1        = 1;

    // Reset values
    localparam logic        RST_BIT         = 1'h0;
    localparam logic [1:0]  RST_FIELD       = 2'h0;
    localparam logic [3:0]  RST_PWR         = 4'h0;

    typedef enum {
        HSC_SETTLE,
        HSC_RUN
    } hsc_state_t;

endpackage : hsc_pkg

// ### design/hsc_strap_config.sv
// Strap latch and multi-function pin control for a four-port hub.
// Assumes hub core supplies link status and SMBus register values as plain ports.
`timescale 1ns/1ps
`default_nettype none

module hsc_strap_config #(
    parameter int PORTS = hsc_pkg::PORT_COUNT
) (
    input  wire logic             mclk_i,                          // 20 MHz clock
    input  wire logic             rst_n_i,                         // Sync reset, active low
    input  wire logic             clk_en_i,                        // Freezes state when low
    input  wire logic             power_polarity_strap_i,          // Polarity strap pin
    input  wire logic             bus_mode_select_i,               // 0 SMBus, 1 I2C
    input  wire logic             billboard_enable_pin_i,          // Billboard pin level
    output logic                  billboard_enable_pin_o,          // Billboard pin drive
    output logic                  billboard_enable_pin_oe_o,       // Billboard pin enable
    input  wire logic             config_state_pin0_i,             // Config pin 0 level
    output logic                  config_state_pin0_o,             // Config pin 0 drive
    output logic                  config_state_pin0_oe_o,          // Config pin 0 enable
    input  wire logic             config_state_pin1_i,             // Config pin 1 level
    output logic                  config_state_pin1_o,             // Config pin 1 drive
    output logic                  config_state_pin1_oe_o,          // Config pin 1 enable
    input  wire logic [PORTS-1:0] port_power_request_i,            // Core power requests
    output logic      [PORTS-1:0] port_power_enable_out_o,         // Port power pins
    input  wire logic             status_output_enable_i,          // Status output enable bit
    input  wire logic             upstream_highspeed_link_flag_i,  // Upstream HS linked
    input  wire logic             upstream_superspeed_link_i,      // Upstream SS linked
    input  wire logic             upstream_highspeed_sleep_flag_i, // Upstream HS suspended
    input  wire logic             charge_enabled_any_i,            // Charging on any port
    input  wire logic             reg_billboard_enable_i,          // SMBus billboard bit
    input  wire logic [1:0]       reg_config_state_i,              // SMBus state field
    input  wire logic             ganged_wr_i,                     // Host write strobe
    input  wire logic             ganged_wdata_i,                  // Host write value
    input  wire logic             full_auto_wr_i,                  // Host write strobe
    input  wire logic             full_auto_wdata_i,               // Host write value
    input  wire logic             switch_absent_wr_i,              // Host write strobe
    input  wire logic             switch_absent_wdata_i,           // Host write value
    input  wire logic             auto_disable_wr_i,               // Host write strobe
    input  wire logic             auto_disable_wdata_i,            // Host write value
    output logic                  i2c_mode_o,                      // Current bus mode is I2C
    output logic                  straps_valid_o,                  // Straps latched
    output logic                  power_polarity_o,                // Latched polarity
    output logic                  ganged_power_o,                  // Ganged power control
    output logic                  full_automatic_charge_enable_o,  // Full-auto charge bit
    output logic                  power_switch_absent_o,           // No switches fitted
    output logic                  charge_auto_mode_disable_o,      // Auto-mode disable bit
    output logic                  billboard_present_o,             // Billboard enabled
    output logic [1:0]            billboard_config_state_field_o   // Billboard state field
);

    localparam int NPIN = 5;

    typedef struct packed {
        hsc_pkg::hsc_state_t state;
        logic [2:0]          settle;
        logic                polarity;
        logic                ganged;
        logic                full_auto;
        logic                sw_absent;
        logic                auto_dis;
        logic [PORTS-1:0]    pwr;
        logic                bb_present;
        logic [1:0]          cfg_field;
        logic                bb_drv;
        logic                cfg0_drv;
        logic                cfg1_drv;
        logic                pin_oe;
    } hsc_state_vec_t;

    hsc_state_vec_t r;
    hsc_state_vec_t next_r;

    logic [NPIN-1:0] pin_level;
    logic            pol_s;
    logic            mode_s;
    logic            bb_s;
    logic            cfg0_s;
    logic            cfg1_s;
    logic            smbus;

    // Apply polarity to a set of active-high requests
    function automatic logic [PORTS-1:0] hsc_apply_pol(
        input logic             pol,
        input logic [PORTS-1:0] req
    );
        return (pol == hsc_pkg::POL_ACTIVE_HIGH) ? req : ~req;
    endfunction : hsc_apply_pol

    hsc_pin_sync #(
        .WIDTH   (NPIN)
    ) hsc_pin_sync_inst (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .clk_en_i(clk_en_i),
        .pin_i   ({config_state_pin1_i, config_state_pin0_i, billboard_enable_pin_i,
                   bus_mode_select_i, power_polarity_strap_i}),
        .level_o (pin_level)
    );

    assign pol_s  = pin_level[0];
    assign mode_s = pin_level[1];
    assign bb_s   = pin_level[2];
    assign cfg0_s = pin_level[3];
    assign cfg1_s = pin_level[4];
    assign smbus  = (mode_s == hsc_pkg::MODE_SMBUS);

    always_comb
    begin
        next_r = r;
        case (r.state)
            hsc_pkg::HSC_SETTLE:
            begin
                // Filtered level lags the pin by four edges after reset
                if (r.settle == hsc_pkg::SETTLE_CYCLES)
                begin
                    next_r.state    = hsc_pkg::HSC_RUN;
                    next_r.polarity = pol_s;
                    if (smbus)
                    begin
                        next_r.ganged = bb_s;
                        if (charge_enabled_any_i)
                        begin
                            next_r.full_auto = cfg0_s;
                        end
                        else
                        begin
                            next_r.sw_absent = cfg0_s;
                        end
                        next_r.auto_dis = cfg1_s;
                    end
                end
                else
                begin
                    next_r.settle = r.settle + 3'h1;
                end
            end
            hsc_pkg::HSC_RUN:
            begin
                // Host overrides of latched settings
                if (ganged_wr_i)
                begin
                    next_r.ganged = ganged_wdata_i;
                end
                if (full_auto_wr_i)
                begin
                    next_r.full_auto = full_auto_wdata_i;
                end
                if (switch_absent_wr_i)
                begin
                    next_r.sw_absent = switch_absent_wdata_i;
                end
                if (auto_disable_wr_i)
                begin
                    next_r.auto_dis = auto_disable_wdata_i;
                end
                next_r.pwr = hsc_apply_pol(r.polarity, port_power_request_i);
                if (smbus)
                begin
                    next_r.bb_present = reg_billboard_enable_i;
                    next_r.cfg_field  = reg_config_state_i;
                    next_r.pin_oe     = status_output_enable_i;
                    next_r.bb_drv     = upstream_highspeed_link_flag_i;
                    next_r.cfg0_drv   = upstream_superspeed_link_i;
                    next_r.cfg1_drv   = upstream_highspeed_sleep_flag_i;
                end
                else
                begin
                    next_r.bb_present = bb_s;
                    next_r.cfg_field[hsc_pkg::CFG_BIT0] = cfg0_s;
                    next_r.cfg_field[hsc_pkg::CFG_BIT1] = cfg1_s;
                    next_r.pin_oe     = hsc_pkg::RST_BIT;
                    next_r.bb_drv     = hsc_pkg::RST_BIT;
                    next_r.cfg0_drv   = hsc_pkg::RST_BIT;
                    next_r.cfg1_drv   = hsc_pkg::RST_BIT;
                end
            end
            default:
            begin
                next_r.state = hsc_pkg::HSC_SETTLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            r.state      <= hsc_pkg::HSC_SETTLE;
            r.settle     <= hsc_pkg::SETTLE_INIT;
            r.polarity   <= hsc_pkg::POL_ACTIVE_LOW;
            r.ganged     <= hsc_pkg::PWR_INDIVIDUAL;
            r.full_auto  <= hsc_pkg::RST_BIT;
            r.sw_absent  <= hsc_pkg::RST_BIT;
            r.auto_dis   <= hsc_pkg::RST_BIT;
            r.pwr        <= hsc_pkg::RST_PWR;
            r.bb_present <= hsc_pkg::RST_BIT;
            r.cfg_field  <= hsc_pkg::RST_FIELD;
            r.bb_drv     <= hsc_pkg::RST_BIT;
            r.cfg0_drv   <= hsc_pkg::RST_BIT;
            r.cfg1_drv   <= hsc_pkg::RST_BIT;
            r.pin_oe     <= hsc_pkg::RST_BIT;
        end
        else if (clk_en_i)
        begin
            r <= next_r;
        end
    end

    assign billboard_enable_pin_o         = r.bb_drv;
    assign billboard_enable_pin_oe_o      = r.pin_oe;
    assign config_state_pin0_o            = r.cfg0_drv;
    assign config_state_pin0_oe_o         = r.pin_oe;
    assign config_state_pin1_o            = r.cfg1_drv;
    assign config_state_pin1_oe_o         = r.pin_oe;
    assign port_power_enable_out_o        = r.pwr;
    assign i2c_mode_o                     = ~smbus;
    assign straps_valid_o                 = (r.state == hsc_pkg::HSC_RUN);
    assign power_polarity_o               = r.polarity;
    assign ganged_power_o                 = r.ganged;
    assign full_automatic_charge_enable_o = r.full_auto;
    assign power_switch_absent_o          = r.sw_absent;
    assign charge_auto_mode_disable_o     = r.auto_dis;
    assign billboard_present_o            = r.bb_present;
    assign billboard_config_state_field_o = r.cfg_field;

endmodule : hsc_strap_config

`default_nettype wire

// ### test/hsc_board_model.sv
// Board straps on the three shared pins: resistor level unless the device drives.
// Assumes the bench sets strap levels only while the device is not latching.
`timescale 1ns/1ps
`default_nettype none

module hsc_board_model (
    input  wire logic [2:0] strap_i, // Resistor levels: cfg1, cfg0, billboard
    input  wire logic [2:0] drv_i,   // Device drive values
    input  wire logic [2:0] oe_i,    // Device drive enables
    output logic      [2:0] pin_o,   // Resolved pin levels
    output logic            test_o   // Factory test pin level
);
    localparam logic TEST_PIN_LEVEL = 1'h0;

    assign test_o = TEST_PIN_LEVEL;

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            pin_o[i] = oe_i[i] ? drv_i[i] : strap_i[i];
        end
    end
endmodule : hsc_board_model

`default_nettype wire

// ### test/hsc_strap_config_asserts.sv
// Checker for the strap configuration block, bound into its top module.
// Assumes clk_en_i stays high and straps hold steady through each latch.
`timescale 1ns/1ps
`default_nettype none

module hsc_strap_config_asserts #(
    parameter int PORTS = 4
) (
    input wire logic             mclk_i,
    input wire logic             rst_n_i,
    input wire logic             power_polarity_strap_i,
    input wire logic [PORTS-1:0] port_power_request_i,
    input wire logic [PORTS-1:0] port_power_enable_out_o,
    input wire logic             i2c_mode_o,
    input wire logic             straps_valid_o,
    input wire logic             power_polarity_o,
    input wire logic             reg_billboard_enable_i,
    input wire logic             billboard_present_o,
    input wire logic [1:0]       reg_config_state_i,
    input wire logic [1:0]       billboard_config_state_field_o,
    input wire logic             status_output_enable_i,
    input wire logic             billboard_enable_pin_oe_o,
    input wire logic             config_state_pin0_oe_o,
    input wire logic             config_state_pin1_oe_o,
    input wire logic             billboard_enable_pin_o,
    input wire logic             config_state_pin0_o,
    input wire logic             config_state_pin1_o,
    input wire logic             upstream_highspeed_link_flag_i,
    input wire logic             upstream_superspeed_link_i,
    input wire logic             upstream_highspeed_sleep_flag_i,
    input wire logic             ganged_wr_i,
    input wire logic             ganged_wdata_i,
    input wire logic             ganged_power_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_run;
        straps_valid_o && $past(straps_valid_o);
    endsequence
    sequence s_smbus;
        s_run ##0 !$past(i2c_mode_o);
    endsequence

    a_latch_moment:
    assert property ($rose(rst_n_i) |-> (!straps_valid_o) [*4] ##[1:2] straps_valid_o)
        else $error("strap latch edge wrong");
    a_polarity_latch:
    assert property ($rose(straps_valid_o) |-> power_polarity_o == power_polarity_strap_i)
        else $error("polarity not latched");
    a_power_apply:
    assert property (s_run |-> port_power_enable_out_o == (power_polarity_o ?
        $past(port_power_request_i) : ~$past(port_power_request_i)))
        else $error("port power polarity wrong");
    a_bb_register:
    assert property (s_smbus |-> billboard_present_o == $past(reg_billboard_enable_i))
        else $error("billboard not from register");
    a_field_register:
    assert property (s_smbus |-> billboard_config_state_field_o == $past(reg_config_state_i))
        else $error("state field not from register");
    a_status_enable:
    assert property (s_run |-> {billboard_enable_pin_oe_o, config_state_pin0_oe_o,
        config_state_pin1_oe_o} == {3{!$past(i2c_mode_o) && $past(status_output_enable_i)}})
        else $error("pin enable wrong");
    a_hs_status:
    assert property (s_smbus |-> billboard_enable_pin_o == $past(upstream_highspeed_link_flag_i))
        else $error("hs link drive wrong");
    a_ss_status:
    assert property (s_smbus |-> config_state_pin0_o == $past(upstream_superspeed_link_i))
        else $error("ss link drive wrong");
    a_sleep_status:
    assert property (s_smbus |-> config_state_pin1_o == $past(upstream_highspeed_sleep_flag_i))
        else $error("suspend drive wrong");
    a_ganged_write:
    assert property ($past(straps_valid_o) && $past(ganged_wr_i) |->
        ganged_power_o == $past(ganged_wdata_i))
        else $error("ganged override lost");
endmodule : hsc_strap_config_asserts

bind hsc_strap_config hsc_strap_config_asserts #(.PORTS(PORTS)) hsc_strap_config_asserts_inst (
    .mclk_i, .rst_n_i, .power_polarity_strap_i, .port_power_request_i, .port_power_enable_out_o,
    .i2c_mode_o, .straps_valid_o, .power_polarity_o, .reg_billboard_enable_i,
    .billboard_present_o, .reg_config_state_i, .billboard_config_state_field_o,
    .status_output_enable_i, .billboard_enable_pin_oe_o, .config_state_pin0_oe_o,
    .config_state_pin1_oe_o, .billboard_enable_pin_o, .config_state_pin0_o,
    .config_state_pin1_o, .upstream_highspeed_link_flag_i, .upstream_superspeed_link_i,
    .upstream_highspeed_sleep_flag_i, .ganged_wr_i, .ganged_wdata_i, .ganged_power_o
);

`default_nettype wire

// ### test/test_hsc_strap_config.sv
// Self-checking bench for the strap configuration block.
// Assumes the board model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, s) \
    begin checked++; if ((s) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end

module test_hsc_strap_config;
    logic       mclk_i = 1'h0;
    logic       rst_n_i = 1'h0;
    logic       mode = 1'h0, pol = 1'h0, charge = 1'h0, sts = 1'h0;
    logic       hs = 1'h0, ss = 1'h0, slp = 1'h0, regbb = 1'h0;
    logic [1:0] regcfg = 2'h0;
    logic [3:0] req = 4'h0, wr = 4'h0, wd = 4'h0;
    logic [2:0] strap = 3'h0;
    logic [2:0] pin, drv, oe;
    logic [3:0] pwr, latched;
    logic       i2c, valid, polo, present, test;
    logic [1:0] field;
    int         err_count = 0;
    int         checked = 0;

    always #25 mclk_i = ~mclk_i;

    hsc_board_model hsc_board_model_inst (.strap_i(strap), .drv_i(drv), .oe_i(oe), .pin_o(pin),
        .test_o(test));

    hsc_strap_config hsc_strap_config_inst (
        .mclk_i, .rst_n_i, .clk_en_i(1'h1), .power_polarity_strap_i(pol),
        .bus_mode_select_i(mode), .billboard_enable_pin_i(pin[0]),
        .billboard_enable_pin_o(drv[0]), .billboard_enable_pin_oe_o(oe[0]),
        .config_state_pin0_i(pin[1]), .config_state_pin0_o(drv[1]),
        .config_state_pin0_oe_o(oe[1]), .config_state_pin1_i(pin[2]),
        .config_state_pin1_o(drv[2]), .config_state_pin1_oe_o(oe[2]),
        .port_power_request_i(req), .port_power_enable_out_o(pwr),
        .status_output_enable_i(sts), .upstream_highspeed_link_flag_i(hs),
        .upstream_superspeed_link_i(ss), .upstream_highspeed_sleep_flag_i(slp),
        .charge_enabled_any_i(charge), .reg_billboard_enable_i(regbb),
        .reg_config_state_i(regcfg), .ganged_wr_i(wr[0]), .ganged_wdata_i(wd[0]),
        .full_auto_wr_i(wr[1]), .full_auto_wdata_i(wd[1]), .switch_absent_wr_i(wr[2]),
        .switch_absent_wdata_i(wd[2]), .auto_disable_wr_i(wr[3]),
        .auto_disable_wdata_i(wd[3]), .i2c_mode_o(i2c), .straps_valid_o(valid),
        .power_polarity_o(polo), .ganged_power_o(latched[0]),
        .full_automatic_charge_enable_o(latched[1]), .power_switch_absent_o(latched[2]),
        .charge_auto_mode_disable_o(latched[3]), .billboard_present_o(present),
        .billboard_config_state_field_o(field)
    );

    task wt(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : wt

    task boot(input logic m, input logic p, input logic [2:0] s, input logic c);
        @(posedge mclk_i);
        rst_n_i <= 1'h0;
        mode <= m;
        pol <= p;
        strap <= s;
        charge <= c;
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        wt(8);
        `CHK("valid", 1'h1, valid)
        `CHK("polarity", p, polo)
        `CHK("mode", m, i2c)
    endtask : boot

    task end_sim;
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (1000) @(posedge mclk_i);
        err_count++;
        end_sim();
    end

    initial
    begin
        boot(1'h0, 1'h0, 3'h3, 1'h0);
        `CHK("straps", 4'h5, latched)
        `CHK("test pin", 1'h0, test)
        @(posedge mclk_i);
        req <= 4'h6;
        sts <= 1'h1;
        hs <= 1'h1;
        slp <= 1'h1;
        regcfg <= 2'h2;
        wt(1);
        `CHK("power", 4'h9, pwr)
        `CHK("enable", 3'h7, oe)
        `CHK("pins", 3'h5, pin)
        `CHK("present", 1'h0, present)
        `CHK("field", 2'h2, field)
        @(posedge mclk_i);
        sts <= 1'h0;
        hs <= 1'h0;
        ss <= 1'h1;
        regbb <= 1'h1;
        regcfg <= 2'h1;
        wt(1);
        `CHK("enable", 3'h0, oe)
        `CHK("drive", 3'h6, drv)
        `CHK("present", 1'h1, present)
        `CHK("field", 2'h1, field)
        @(posedge mclk_i);
        wr <= 4'hF;
        wd <= 4'hA;
        @(posedge mclk_i);
        wr <= 4'h1;
        wd <= 4'h1;
        @(posedge mclk_i);
        wr <= 4'h0;
        wt(1);
        `CHK("override", 4'hB, latched)
        boot(1'h0, 1'h1, 3'h6, 1'h1);
        `CHK("straps", 4'hA, latched)
        `CHK("power", 4'h6, pwr)
        @(posedge mclk_i);
        sts <= 1'h1;
        boot(1'h1, 1'h1, 3'h5, 1'h0);
        `CHK("straps", 4'h0, latched)
        `CHK("enable", 3'h0, oe)
        `CHK("present", 1'h1, present)
        `CHK("field", 2'h2, field)
        @(posedge mclk_i);
        strap <= 3'h2;
        wt(5);
        `CHK("present", 1'h0, present)
        `CHK("field", 2'h1, field)
        end_sim();
    end
endmodule : test_hsc_strap_config

`default_nettype wire
